// ===== design/adcref_ctrl.sv
// Top of the converter reference selection block: register slave,
// reference control register, readback and output drive.
// Assumes a single-cycle SFR bus on core_clk with separate read and
// write strobes, and a converter core on the same clock.
`timescale 1ns/1ps
`default_nettype none

module adcref_ctrl
    import adcref_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [3:0] sfrPage,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrStb,
    input wire logic sfrRdStb,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    input wire logic convTracking,
    input wire logic convSampling,
    input wire logic convConverting,
    input wire logic muxTempSel,
    input wire logic trimLoad,
    input wire logic [9:0] trimValue,
    output logic [1:0] refSourceSelect,
    output logic hsRefEnable,
    output logic analogGroundSel,
    output logic tempSensorEnable
);

    // =========================================================
    // Address decoding
    // The offset bytes live on their own page so a stray write to the
    // control page cannot alias onto them.
    wire hitCtrl = (sfrPage == PAGE_CTRL)
        && (sfrAddr == ADDR_REFERENCE_CONTROL);
    wire hitOffLow = (sfrPage == PAGE_OFFSET)
        && (sfrAddr == ADDR_TEMP_OFFSET_LOW);
    wire hitOffHigh = (sfrPage == PAGE_OFFSET)
        && (sfrAddr == ADDR_TEMP_OFFSET_HIGH);
    wire ctrlWrite = sfrWrStb & hitCtrl;

    // =========================================================
    // Reference control register
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;

    // Only the three live fields take written data
    assign nxt_ctrl = ctrlWrite ?
        (sfrWdata & CTRL_WRITE_MASK) : ctrl_ff;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_ff <= CTRL_RESET;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Straight from the register so the analog mux sees a clean level
    assign refSourceSelect = ctrl_ff[REF_SEL_MSB:REF_SEL_LSB];
    assign tempSensorEnable = ctrl_ff[TEMP_EN_BIT];

    // =========================================================
    // Ground selection and fast reference gating
    // Fed from the next control value so a write reaches the pins on
    // the very edge that stores it.
    adcref_gnd_mux u_gnd_mux (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .nxtGndSel(nxt_ctrl[GND_SEL_BIT]),
        .nxtRefSel(nxt_ctrl[REF_SEL_MSB:REF_SEL_LSB]),
        .convTracking(convTracking),
        .convSampling(convSampling),
        .convConverting(convConverting),
        .muxTempSel(muxTempSel),
        .analogGroundSel(analogGroundSel),
        .hsRefEnable(hsRefEnable)
    );

    // =========================================================
    // Factory temperature offset
    logic [7:0] offsetHigh;
    logic [7:0] offsetLow;

    adcref_offset_store u_offset (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .trimLoad(trimLoad),
        .trimValue(trimValue),
        .offsetHigh(offsetHigh),
        .offsetLow(offsetLow),
        .offsetLoaded()
    );

    // =========================================================
    // Read data: registered, held until the next read strobe
    logic [7:0] rdata_ff;
    logic [7:0] readMux;

    // Unmapped addresses answer zero; the offset bytes have no write path
    assign readMux = hitCtrl ? ctrl_ff :
        hitOffHigh ? offsetHigh :
        hitOffLow ? offsetLow : READ_IDLE;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= READ_IDLE;
        end else if (sfrRdStb) begin
            rdata_ff <= readMux;
        end
    end

    assign sfrRdata = rdata_ff;

    // =========================================================
    // Checks on the register path and analog controls
    wire [1:0] liveRef = refSourceSelect;
    wire liveHs = (liveRef == REF_HIGH_SPEED);
    wire convBusy = convTracking | convSampling | convConverting;

    sequence sCtrlWrite;
        sfrWrStb && hitCtrl;
    endsequence

    sequence sCtrlRead;
        sfrRdStb && hitCtrl && !sfrWrStb;
    endsequence

    sequence sOffLowRead;
        sfrRdStb && hitOffLow;
    endsequence

    sequence sOffHighRead;
        sfrRdStb && hitOffHigh && !trimLoad;
    endsequence

    // Written reference field shows on the very next edge
    AST_REFSEL_WRITE: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        sCtrlWrite |=> refSourceSelect == $past(sfrWdata[4:3]))
        else $error("reference select did not follow write");

    // Sensor enable tracks the written bit, then holds without writes
    AST_TEMPEN_WRITE: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        sCtrlWrite ##1 !ctrlWrite[*2] |-> tempSensorEnable
            == $past(sfrWdata[2], 2) && $stable(tempSensorEnable))
        else $error("sensor enable not taken from write");

    // Reference select and sensor enable never move without a control write
    AST_CTRL_HOLD: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !ctrlWrite |=> $stable(refSourceSelect) && $stable(tempSensorEnable))
        else $error("control outputs changed without a write");

    // Fast reference enabled one cycle after busy with it selected
    AST_HSREF_ON: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (liveHs && convBusy && !ctrlWrite) |=> hsRefEnable)
        else $error("fast reference not powered while in use");

    // Fast reference is off whenever it was not needed
    AST_HSREF_OFF: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        hsRefEnable |-> $past(convBusy) && liveHs)
        else $error("fast reference powered while idle");

    // Temperature sampling always uses chip ground
    AST_TEMP_SAMPLE_GND: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (muxTempSel && convSampling) |=> !analogGroundSel)
        else $error("analog ground used while sampling sensor");

    // Fast reference conversion always uses chip ground
    AST_HS_CONV_GND: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (liveHs && convConverting && !ctrlWrite) |=> !analogGroundSel)
        else $error("analog ground used in fast reference conversion");

    // Without an override the ground follows the stored bit
    AST_GND_FOLLOW: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (!ctrlWrite && !(muxTempSel && convSampling)
            && !(liveHs && convConverting))
        |=> analogGroundSel == ctrl_ff[GND_SEL_BIT])
        else $error("ground select not following control bit");

    // Control readback keeps unused bits at zero
    AST_CTRL_UNUSED: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        sCtrlRead |=> sfrRdata[7:6] == 2'h0 && sfrRdata[1:0] == 2'h0
            && sfrRdata[4:3] == refSourceSelect)
        else $error("control readback unused bits not zero");

    // Low offset byte reads zero below bit 6
    AST_OFFLOW_ZERO: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        sOffLowRead |=> sfrRdata[5:0] == 6'h00)
        else $error("low offset unused bits not zero");

    // High offset byte carries the upper eight offset bits
    AST_OFFHIGH_READ: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        sOffHighRead |=> sfrRdata == $past(offsetHigh))
        else $error("high offset byte wrong");

    // =========================================================
    // Multi-step checks: reset release, write paths, factory offset
    // The trim checks demand exact gaps, so a second load between the
    // load and the read cannot pass off a newer value as the old one.
    sequence sNoOverride;
        !convSampling && !convConverting;
    endsequence

    sequence sConvEnd;
        convConverting ##1 !convBusy;
    endsequence

    sequence sTrimHigh;
        trimLoad ##1 !trimLoad ##1 sOffHighRead;
    endsequence

    sequence sTrimLow;
        trimLoad ##1 !trimLoad[*2] ##1 sOffLowRead;
    endsequence

    // Leaving reset shows the idle selection and a quiet read port
    AST_RESET_STATE: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        $fell(sys_rst) |-> ctrl_ff == CTRL_RESET && !hsRefEnable
            && !analogGroundSel && sfrRdata == READ_IDLE)
        else $error("outputs not at reset values after release");

    // Unused control bits never store; the ground bit stores as written
    AST_CTRL_MASK: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        sCtrlWrite |=> ctrl_ff[7:6] == 2'h0 && ctrl_ff[1:0] == 2'h0
            && ctrl_ff[GND_SEL_BIT] == $past(sfrWdata[5]))
        else $error("control register stored wrong bits");

    // With no override active a written ground bit reaches the pin at once
    AST_GND_WRITE: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (sCtrlWrite ##0 sNoOverride)
        |=> analogGroundSel == $past(sfrWdata[5]))
        else $error("ground select lagged a control write");

    // Picking the fast reference mid-conversion powers it on the next edge
    AST_HSREF_WRITE: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (sCtrlWrite ##0 (sfrWdata[4:3] == REF_HIGH_SPEED && convBusy))
        |=> hsRefEnable)
        else $error("fast reference not powered after write");

    // Any other source keeps the fast reference dark
    AST_HSREF_UNSEL: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (!liveHs && !ctrlWrite) |=> !hsRefEnable)
        else $error("fast reference powered while not selected");

    // Once the converter goes idle the fast reference powers down
    AST_HSREF_DROP: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        sConvEnd |=> !hsRefEnable)
        else $error("fast reference left on after conversion");

    // A loaded value reads back in the high byte two cycles later
    AST_TRIM_HIGH: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        sTrimHigh |=> sfrRdata == $past(trimValue[9:2], 3))
        else $error("high offset byte not the loaded value");

    // The two low offset bits follow in the top of the low byte
    AST_TRIM_LOW: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        sTrimLow |=> sfrRdata[7:6] == $past(trimValue[1:0], 4))
        else $error("low offset bits not the loaded value");

    // Writes aimed at the low offset byte leave it untouched
    AST_OFFLOW_WRITE: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (sfrWrStb && hitOffLow && !trimLoad) |=> $stable(offsetLow))
        else $error("low offset byte changed by a write");

    // Read data holds between read strobes
    AST_RDATA_HOLD: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !sfrRdStb |=> $stable(sfrRdata))
        else $error("read data moved without a read strobe");

    // A read beside a write returns the setting from before the write
    AST_RD_WR_OLD: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (sfrRdStb && ctrlWrite) |=> sfrRdata[4:3] == $past(refSourceSelect))
        else $error("read beside write did not return old value");

endmodule

`default_nettype wire

// ===== design/adcref_gnd_mux.sv
// Ground selection and high-speed reference power gating.
// Assumes converter phase flags come from logic on core_clk.
`timescale 1ns/1ps
`default_nettype none

module adcref_gnd_mux
    import adcref_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic nxtGndSel,
    input wire logic [1:0] nxtRefSel,
    input wire logic convTracking,
    input wire logic convSampling,
    input wire logic convConverting,
    input wire logic muxTempSel,
    output logic analogGroundSel,
    output logic hsRefEnable
);

    logic gnd_ff;
    logic hsEn_ff;
    logic nxt_gnd;
    logic nxt_hsEn;
    wire hsSelected = (nxtRefSel == REF_HIGH_SPEED);
    wire convBusy = convTracking | convSampling | convConverting;
    wire forceChipGnd = (muxTempSel & convSampling)
        | (hsSelected & convConverting);

    // =========================================================
    // Overrides beat the software ground choice in their phases
    assign nxt_gnd = nxtGndSel & ~forceChipGnd;
    // Power the fast reference only while the converter works
    assign nxt_hsEn = hsSelected & convBusy;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gnd_ff <= 1'b0;
            hsEn_ff <= 1'b0;
        end else begin
            gnd_ff <= nxt_gnd;
            hsEn_ff <= nxt_hsEn;
        end
    end

    assign analogGroundSel = gnd_ff;
    assign hsRefEnable = hsEn_ff;

endmodule

`default_nettype wire

// ===== design/adcref_offset_store.sv
// Holds the factory temperature offset and splits it into two bytes.
// Assumes the trim loader runs on core_clk and pulses trimLoad once the
// production value is valid after reset.
`timescale 1ns/1ps
`default_nettype none

module adcref_offset_store
    import adcref_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic trimLoad,
    input wire logic [9:0] trimValue,
    output logic [7:0] offsetHigh,
    output logic [7:0] offsetLow,
    output logic offsetLoaded
);

    logic [9:0] offset_ff;
    logic loaded_ff;

    // =========================================================
    // Capture the production value; reset takes a constant only
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            offset_ff <= OFFSET_RESET;
            loaded_ff <= 1'b0;
        end else if (trimLoad) begin
            offset_ff <= trimValue;
            loaded_ff <= 1'b1;
        end
    end

    // Byte views: unused low bits are wired to zero, so writes cannot land
    assign offsetHigh = offset_ff[9:2];
    assign offsetLow = {offset_ff[1:0], 6'h00};
    assign offsetLoaded = loaded_ff;

endmodule

`default_nettype wire

// ===== design/adcref_pkg.sv
// Shared constants for the converter reference selection block.
// Assumes an 8-bit special-function-register bus with page select,
// clocked by the same core clock as the block.
package adcref_pkg;

    // =========================================================
    // Register pages and addresses
    localparam logic [3:0] PAGE_CTRL = 4'h0;
    localparam logic [3:0] PAGE_OFFSET = 4'hf;
    localparam logic [7:0] ADDR_TEMP_OFFSET_LOW = 8'h8d;
    localparam logic [7:0] ADDR_TEMP_OFFSET_HIGH = 8'h8e;
    localparam logic [7:0] ADDR_REFERENCE_CONTROL = 8'hd1;

    // =========================================================
    // Reference control field layout and reset value
    localparam int GND_SEL_BIT = 5;
    localparam int REF_SEL_MSB = 4;
    localparam int REF_SEL_LSB = 3;
    localparam int TEMP_EN_BIT = 2;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h3c;
    localparam logic [7:0] CTRL_RESET = 8'h18;

    // =========================================================
    // Reference source codes
    localparam logic [1:0] REF_EXT_PIN = 2'h0;
    localparam logic [1:0] REF_MAIN_SUPPLY = 2'h1;
    localparam logic [1:0] REF_DIG_SUPPLY = 2'h2;
    localparam logic [1:0] REF_HIGH_SPEED = 2'h3;

    // =========================================================
    // Temperature offset layout
    localparam int OFFSET_WIDTH = 10;
    localparam int OFFSET_LOW_LSB = 6;
    localparam logic [9:0] OFFSET_RESET = 10'h000;
    localparam logic [7:0] READ_IDLE = 8'h00;

endpackage

// ===== tb/adc_reference_select_ctrl_tb.sv
// Self-checking bench for the reference selection block.
// Assumes a reference model here mirrors every edge the design takes.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
    err_count++; $display("MISMATCH %0t %h vs %h", $time, a, b); end end
module adc_reference_select_ctrl_tb;
    import adcref_pkg::*;
    logic core_clk = 1'b0, sys_rst = 1'b1, sfrWrStb = 1'b0, sfrRdStb = 1'b0;
    logic [3:0] sfrPage = 4'h0;
    logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata;
    logic muxTempSel = 1'b0, trimLoad = 1'b0, startConv = 1'b0;
    logic slowMode = 1'b0, trk, smp, cnv, busy, hs, gnd, ts;
    logic [9:0] trimValue = 10'h000, offM;
    logic [1:0] refSel;
    logic [7:0] ctrlM, rdM;
    logic [12:0] expQ[$];
    logic [12:0] ex;
    int err_count = 0, cmp_count = 0, cyc = 0, i;
    adcref_ctrl adcref_ctrl_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .sfrPage(sfrPage), .sfrAddr(sfrAddr), .sfrWrStb(sfrWrStb),
        .sfrRdStb(sfrRdStb), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
        .convTracking(trk), .convSampling(smp), .convConverting(cnv),
        .muxTempSel(muxTempSel), .trimLoad(trimLoad),
        .trimValue(trimValue), .refSourceSelect(refSel),
        .hsRefEnable(hs), .analogGroundSel(gnd), .tempSensorEnable(ts));
    adcref_conv_model adcref_conv_model_i (.core_clk(core_clk),
        .sys_rst(sys_rst), .startConv(startConv), .slowMode(slowMode),
        .convTracking(trk), .convSampling(smp), .convConverting(cnv),
        .convBusy(busy));
    always #10 core_clk = ~core_clk;
    // =========================================================
    // Reference model: notes what the next edge must produce
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlM = CTRL_RESET;
            offM = OFFSET_RESET;
            rdM = READ_IDLE;
            expQ.delete();
        end else begin
            if (sfrRdStb)
                rdM = (sfrPage == PAGE_CTRL &&
                       sfrAddr == ADDR_REFERENCE_CONTROL) ? ctrlM :
                      (sfrPage != PAGE_OFFSET) ? 8'h00 :
                      (sfrAddr == ADDR_TEMP_OFFSET_LOW) ?
                          {offM[1:0], 6'h00} :
                      (sfrAddr == ADDR_TEMP_OFFSET_HIGH) ? offM[9:2] : 8'h00;
            if (sfrWrStb && sfrPage == PAGE_CTRL &&
                sfrAddr == ADDR_REFERENCE_CONTROL)
                ctrlM = sfrWdata & 8'h3c;
            if (trimLoad)
                offM = trimValue;
            ex = {rdM, ctrlM[4:3], ctrlM[4:3] == 2'h3 && (trk | smp | cnv),
                  ctrlM[5] && !(muxTempSel && smp) &&
                  !(ctrlM[4:3] == 2'h3 && cnv), ctrlM[2]};
            expQ.push_back(ex);
        end
    end
    // =========================================================
    // Monitor: settled outputs checked mid-cycle against oldest note
    always @(negedge core_clk) begin
        if (!sys_rst && expQ.size() > 0) begin
            ex = expQ.pop_front();
            `CHK(sfrRdata, ex[12:5])
            `CHK(refSel, ex[4:3])
            `CHK(hs, ex[2])
            `CHK(gnd, ex[1])
            `CHK(ts, ex[0])
        end
    end
    // Whole run ceiling; normal run is well under a thousand cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 20000) begin
            err_count++;
            final_report();
        end
    end
    task automatic final_report();
        if (err_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One bus cycle; calls may run back to back, idle() ends a burst
    task automatic bus(input logic w, input logic r, input logic [3:0] pg,
                       input logic [7:0] ad, input logic [7:0] d);
        @(posedge core_clk);
        sfrWrStb <= w;
        sfrRdStb <= r;
        sfrPage <= pg;
        sfrAddr <= ad;
        sfrWdata <= d;
    endtask
    task automatic idle();
        bus(1'b0, 1'b0, 4'h0, 8'h00, 8'h00);
    endtask
    // Run a conversion and wait for the core to go idle again
    task automatic conv(input logic tmp, input logic slw);
        @(posedge core_clk);
        muxTempSel <= tmp;
        slowMode <= slw;
        startConv <= 1'b1;
        @(posedge core_clk);
        startConv <= 1'b0;
        for (i = 0; i < 100 && (busy !== 1'b0 || i < 2); i++)
            @(posedge core_clk);
    endtask
    initial begin
        void'($urandom(32'he5ba));
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        // Reset values, unmapped place and wrong page first
        bus(0, 1, PAGE_CTRL, ADDR_REFERENCE_CONTROL, 8'h00);
        bus(0, 1, PAGE_OFFSET, ADDR_TEMP_OFFSET_HIGH, 8'h00);
        bus(0, 1, PAGE_OFFSET, 8'h90, 8'h00);
        bus(0, 1, PAGE_OFFSET, ADDR_REFERENCE_CONTROL, 8'h00);
        // Offset bytes are read only; trim a value then read both bytes
        bus(1, 0, PAGE_OFFSET, ADDR_TEMP_OFFSET_LOW, 8'hff);
        idle();
        @(posedge core_clk);
        trimLoad <= 1'b1;
        trimValue <= 10'($urandom());
        @(posedge core_clk);
        trimLoad <= 1'b0;
        bus(0, 1, PAGE_OFFSET, ADDR_TEMP_OFFSET_HIGH, 8'h00);
        bus(0, 1, PAGE_OFFSET, ADDR_TEMP_OFFSET_LOW, 8'h00);
        // Every source code with ground pin and sensor on, then a read
        // in the same cycle as a write, then conversions both speeds
        for (int c = 0; c < 8; c++) begin
            bus(1, 0, PAGE_CTRL, ADDR_REFERENCE_CONTROL,
                {2'b11, 1'b1, 2'(c), 1'b1, 2'b11});
            bus(1, 1, PAGE_CTRL, ADDR_REFERENCE_CONTROL,
                (8'($urandom()) & 8'hc7) | {3'b001, 2'(c), 3'b000});
            bus(0, 1, PAGE_CTRL, ADDR_REFERENCE_CONTROL, 8'h00);
            idle();
            conv(c[0] ^ c[2], c[2]);
        end
        // Random back-to-back traffic with overlapping conversions
        repeat (300) begin
            bus(1'($urandom()), 1'($urandom()),
                ($urandom() & 1) ? PAGE_OFFSET : PAGE_CTRL,
                ($urandom() & 1) ? ADDR_REFERENCE_CONTROL :
                8'h8d + 8'($urandom() % 3), 8'($urandom()));
            muxTempSel <= 1'($urandom());
            startConv <= !busy && 1'($urandom());
        end
        idle();
        // Second reset mid-run: idle values must read back afterwards
        startConv <= 1'b0;
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        bus(0, 1, PAGE_CTRL, ADDR_REFERENCE_CONTROL, 8'h00);
        bus(0, 1, PAGE_OFFSET, ADDR_TEMP_OFFSET_LOW, 8'h00);
        idle();
        repeat (3) @(posedge core_clk);
        final_report();
    end
endmodule
`default_nettype wire

// ===== tb/adcref_conv_model.sv
// Converter core stand-in: steps through track, sample and convert.
// Assumes start pulses arrive only while idle; slow stretches phases.
`timescale 1ns/1ps
`default_nettype none
module adcref_conv_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic startConv,
    input wire logic slowMode,
    output logic convTracking,
    output logic convSampling,
    output logic convConverting,
    output logic convBusy
);
    logic [1:0] phase_ff;
    logic [3:0] cnt_ff;
    // =========================================================
    // Phase sequencer; phase 3 wraps back to idle
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_ff <= 2'h0;
            cnt_ff <= 4'h0;
        end else if (phase_ff == 2'h0 && !startConv) begin
            cnt_ff <= 4'h0;
        end else if (phase_ff == 2'h0 || cnt_ff == 4'h0) begin
            phase_ff <= phase_ff + 2'h1;
            cnt_ff <= slowMode ? 4'h9 : 4'h1;
        end else begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end
    assign convTracking = (phase_ff == 2'h1);
    assign convSampling = (phase_ff == 2'h2);
    assign convConverting = (phase_ff == 2'h3);
    assign convBusy = (phase_ff != 2'h0);
endmodule
`default_nettype wire
